// >>> hdl/rau_pkg.sv
package rau_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] ADDR_CLK_CFG = 4'h0;
	localparam logic [3:0] ADDR_TRIM    = 4'h1;
	localparam logic [3:0] ADDR_PAD_CFG = 4'h2;
	localparam logic [3:0] ADDR_ALM_CFG = 4'h3;
	localparam logic [3:0] ADDR_RPT     = 4'h4;
	localparam logic [3:0] ADDR_VAL_HI  = 4'h5;
	localparam logic [3:0] ADDR_VAL_LO  = 4'h6;
	localparam logic [3:0] ADDR_ALM_HI  = 4'h7;
	localparam logic [3:0] ADDR_ALM_LO  = 4'h8;
	localparam logic [3:0] ADDR_KEY     = 4'h9;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_EN      = 7;
	localparam int CFG_ONE     = 6;
	localparam int CFG_UNLOCK  = 5;
	localparam int CFG_SYNC    = 4;
	localparam int CFG_HALF    = 3;
	localparam int CFG_OE      = 2;
	localparam int ALM_EN      = 7;
	localparam int ALM_ENDLESS = 6;
	localparam int ALM_MASK_LO = 2;
	localparam int PAD_SEL_LO  = 1;

	// ----------------------------------------
	// Reset values, keys and field masks
	// ----------------------------------------
	localparam logic [7:0] CFG_RST  = 8'h00;
	localparam logic [7:0] RPT_RST  = 8'h00;
	localparam logic [7:0] KEY_ONE  = 8'h55;
	localparam logic [7:0] KEY_TWO  = 8'hAA;
	localparam logic [7:0] MSK_SEC  = 8'h7F;
	localparam logic [7:0] MSK_HOUR = 8'h3F;
	localparam logic [7:0] MSK_WDAY = 8'h07;
	localparam logic [7:0] MSK_MON  = 8'h1F;
	localparam logic [1:0] SEL_ALM  = 2'h0;
	localparam logic [1:0] SEL_SEC  = 2'h1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int SRC_HZ = 32_768;
	localparam int SRC_CYC = CLK_HZ / SRC_HZ;
	localparam logic [9:0] SRC_LAST = 10'(SRC_CYC - 1);
	localparam logic [13:0] HALF_LAST = 14'h3FFF;
	localparam logic [13:0] SYNC_START = 14'h3FE0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		RAU_KEY_IDLE  = 3'b001,
		RAU_KEY_GOT1  = 3'b010,
		RAU_KEY_ARMED = 3'b100
	} rau_key_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rau_bus_t;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] day;
		logic [7:0] month;
		logic [7:0] year;
	} rau_time_t;

	typedef struct packed {
		logic [7:0]  clk_cfg;
		logic [7:0]  trim;
		logic [7:0]  pad_cfg;
		logic [7:0]  alm_cfg;
		logic [7:0]  rpt;
		rau_time_t   tm;
		rau_time_t   al;
		logic [9:0]  div;
		logic [13:0] pulse;
		logic        half;
		logic        apulse;
		rau_key_t    key;
		logic [7:0]  rd_data;
		logic        irq;
		logic        pin;
	} rau_state_t;

endpackage

// >>> hdl/rau_unit.sv
`timescale 1ns/10ps

// How it works
// RL1: sync flag high just before each second tick
// RL2: value writes need the unlock bit set
// RL3: 55h, AAh, then unlock in next cycle
// RL4: value pointer routes high and low windows
// RL5: high value access decrements pointer, sticks at 00
// RL6: alarm pointer routes alarm windows
// RL7: alarm high access decrements pointer, sticks at 00
// RL8: each minute add trim times four pulses
// RL9: software writes trim only at safe moments
// RL10: alarm enable clears unless repeating
// RL11: interval mask selects compared alarm digits
// RL12: yearly February 29 alarm fires leap years only
// RL13: zero count, no endless: single alarm
// RL14: count decrements per alarm, last alarm disables
// RL15: endless repeat wraps count to FF
// RL16: every alarm raises the interrupt
// RL17: alarm pulse toggles on every alarm
// RL18: pad select picks alarm pulse or seconds
// RL19: sleep does not stop timer or alarm
// RL20: device reset clears repeat count and alarm
// RL21: clock config and count reset at power-on
// RL22: only a seconds write clears prescalers
// RL23: timer enable write ignored while locked
// RL24: counter runs only while enabled
// RL25: unmapped window slots read zero, ignore writes
module rau_unit #(
	parameter int SRC_CYCLES = rau_pkg::SRC_CYC
) (
	input  wire logic          clk_in,
	input  wire logic          reset_n_in,
	input  wire logic          ce_in,
	input  wire logic          dev_reset_in,
	input  wire logic          sleep_in,
	input  wire rau_pkg::rau_bus_t bus_in,
	output logic [7:0]         rd_data_out,
	output logic               alarm_irq_out,
	output logic               clock_pin_out,
	output logic               clock_pin_oe_out
);

	// Last count of the source divider; a shorter source period speeds up a bench.
	localparam logic [9:0] SRC_LAST = 10'(SRC_CYCLES - 1);

	rau_pkg::rau_state_t s_q;
	rau_pkg::rau_state_t s_d;
	logic [8:0]  r;
	logic        tick;
	logic        sec_tick;
	logic        hit;
	logic [7:0]  rd_val;
	logic        locked;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Advances a BCD pair, returning the wrap flag above the new value.
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
			input logic [7:0] hi);
		if (v >= hi) begin
			bcd_inc = {1'b1, lo};
		end else if (v[3:0] >= 4'h9) begin
			bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {1'b0, v + 8'h01};
		end
	endfunction

	// Last day of a BCD month; leap years are the BCD years divisible by four.
	function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02:   last_day = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction

	// Pointer step after a high window access, holding at zero.
	function automatic logic [1:0] ptr_dec(input logic [1:0] p);
		ptr_dec = (p == 2'h0) ? 2'h0 : p - 2'h1;
	endfunction

	// Alarm compare under the interval mask; each level adds to the one below, but day (8) builds on hour (6), not weekday.
	function automatic logic alarm_hit(input logic [3:0] m, input logic st,
			input rau_pkg::rau_time_t t, input rau_pkg::rau_time_t a);
		logic [9:0] ok;
		ok = '0;
		ok[2] = t.sec[3:0] == a.sec[3:0];
		ok[3] = ok[2] && t.sec[6:4] == a.sec[6:4];
		ok[4] = ok[3] && t.min[3:0] == a.min[3:0];
		ok[5] = ok[4] && t.min[6:4] == a.min[6:4];
		ok[6] = ok[5] && t.hour == a.hour;
		ok[7] = ok[6] && t.wday == a.wday;
		ok[8] = ok[6] && t.day == a.day;
		ok[9] = ok[8] && t.month == a.month;
		if (m == 4'h0) begin
			alarm_hit = 1'b1;
		end else if (m == 4'h1) begin
			alarm_hit = st;
		end else if (m <= 4'h9) begin
			alarm_hit = st && ok[m];
		end else begin
			alarm_hit = 1'b0;
		end
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	// Counting first, then alarm, then bus writes, so software has the last word.
	always_comb begin
		s_d = s_q;
		r = '0;
		tick = 1'b0;
		sec_tick = 1'b0;
		hit = 1'b0;
		rd_val = 8'h00;
		locked = !s_q.clk_cfg[rau_pkg::CFG_UNLOCK];
		s_d.irq = 1'b0;
		s_d.rd_data = 8'h00;

		// Source divider and prescaler keep running whatever sleep_in says.
		if (s_q.div == SRC_LAST) begin // RL19
			s_d.div = 10'h000;
			tick = s_q.clk_cfg[rau_pkg::CFG_EN]; // RL24
		end else begin
			s_d.div = s_q.div + 10'h001;
		end

		// Half-second stage; the seconds tick lands on every second wrap.
		if (tick) begin
			s_d.pulse = s_q.pulse + 14'h0001;
			if (s_q.pulse == rau_pkg::HALF_LAST) begin
				s_d.half = !s_q.half;
				sec_tick = s_q.half;
			end
		end

		// Calendar chain on each seconds tick, with the trim once a minute.
		if (sec_tick) begin
			r = bcd_inc(s_q.tm.sec, 8'h00, 8'h59);
			s_d.tm.sec = r[7:0];
			if (r[8]) begin
				// The trim rides on top of the ordinary step, so no pulse is lost.
				s_d.pulse = s_d.pulse + {{4{s_q.trim[7]}}, s_q.trim, 2'b00}; // RL8
				r = bcd_inc(s_q.tm.min, 8'h00, 8'h59);
				s_d.tm.min = r[7:0];
			end
			if (r[8]) begin
				r = bcd_inc(s_q.tm.hour, 8'h00, 8'h23);
				s_d.tm.hour = r[7:0];
			end
			if (r[8]) begin
				s_d.tm.wday = (s_q.tm.wday >= 8'h06) ? 8'h00 : s_q.tm.wday + 8'h01;
				r = bcd_inc(s_q.tm.day, 8'h01, last_day(s_q.tm.month, s_q.tm.year)); // RL12
				s_d.tm.day = r[7:0];
			end
			if (r[8]) begin
				r = bcd_inc(s_q.tm.month, 8'h01, 8'h12);
				s_d.tm.month = r[7:0];
			end
			if (r[8]) begin
				r = bcd_inc(s_q.tm.year, 8'h00, 8'h99);
				s_d.tm.year = r[7:0];
			end
		end

		// Alarm checked on each half-second edge against the new time.
		if (tick && s_q.pulse == rau_pkg::HALF_LAST) begin
			hit = s_q.alm_cfg[rau_pkg::ALM_EN] && alarm_hit(
				s_q.alm_cfg[rau_pkg::ALM_MASK_LO +: 4], sec_tick, s_d.tm, s_q.al); // RL11
		end
		if (hit) begin
			s_d.irq = 1'b1; // RL16
			s_d.apulse = !s_q.apulse; // RL17
			if (s_q.rpt != 8'h00) begin
				s_d.rpt = s_q.rpt - 8'h01; // RL14
			end else if (s_q.alm_cfg[rau_pkg::ALM_ENDLESS]) begin
				s_d.rpt = 8'hFF; // RL15
			end else begin
				s_d.alm_cfg[rau_pkg::ALM_EN] = 1'b0; // RL10 RL13
			end
		end

		// Key sequence: the armed state lives for exactly one cycle.
		if (s_q.key == rau_pkg::RAU_KEY_ARMED) begin
			s_d.key = rau_pkg::RAU_KEY_IDLE;
		end
		if (bus_in.wr) begin
			if (bus_in.addr == rau_pkg::ADDR_KEY && bus_in.wdata == rau_pkg::KEY_ONE) begin
				s_d.key = rau_pkg::RAU_KEY_GOT1; // RL3
			end else if (bus_in.addr == rau_pkg::ADDR_KEY && bus_in.wdata == rau_pkg::KEY_TWO
					&& s_q.key == rau_pkg::RAU_KEY_GOT1) begin
				s_d.key = rau_pkg::RAU_KEY_ARMED; // RL3
			end else begin
				s_d.key = rau_pkg::RAU_KEY_IDLE;
			end
		end

		// Register writes.
		if (bus_in.wr) begin
			unique case (bus_in.addr)
				rau_pkg::ADDR_CLK_CFG: begin
					s_d.clk_cfg[2:0] = bus_in.wdata[2:0];
					if (!locked) begin
						s_d.clk_cfg[rau_pkg::CFG_EN] = bus_in.wdata[rau_pkg::CFG_EN]; // RL23
					end
					if (!bus_in.wdata[rau_pkg::CFG_UNLOCK] || s_q.key == rau_pkg::RAU_KEY_ARMED
							|| !locked) begin
						s_d.clk_cfg[rau_pkg::CFG_UNLOCK] = bus_in.wdata[rau_pkg::CFG_UNLOCK]; // RL3
					end
				end
				rau_pkg::ADDR_TRIM:    s_d.trim = bus_in.wdata; // RL9
				rau_pkg::ADDR_PAD_CFG: s_d.pad_cfg[2:1] = bus_in.wdata[2:1];
				rau_pkg::ADDR_ALM_CFG: s_d.alm_cfg = bus_in.wdata;
				rau_pkg::ADDR_RPT:     s_d.rpt = bus_in.wdata;
				rau_pkg::ADDR_VAL_HI: begin
					if (!locked) begin // RL2
						unique case (s_q.clk_cfg[1:0])
							2'h0: s_d.tm.min = bus_in.wdata & rau_pkg::MSK_SEC; // RL4
							2'h1: s_d.tm.wday = bus_in.wdata & rau_pkg::MSK_WDAY;
							2'h2: s_d.tm.month = bus_in.wdata & rau_pkg::MSK_MON;
							2'h3: s_d.tm.year = s_q.tm.year; // RL25
						endcase
					end
				end
				rau_pkg::ADDR_VAL_LO: begin
					if (!locked) begin // RL2
						unique case (s_q.clk_cfg[1:0])
							2'h0: begin
								s_d.tm.sec = bus_in.wdata & rau_pkg::MSK_SEC; // RL4
								s_d.div = 10'h000; // RL22
								s_d.pulse = 14'h0000;
								s_d.half = 1'b0;
							end
							2'h1: s_d.tm.hour = bus_in.wdata & rau_pkg::MSK_HOUR;
							2'h2: s_d.tm.day = bus_in.wdata & rau_pkg::MSK_HOUR;
							2'h3: s_d.tm.year = bus_in.wdata;
						endcase
					end
				end
				rau_pkg::ADDR_ALM_HI: begin
					unique case (s_q.alm_cfg[1:0])
						2'h0: s_d.al.min = bus_in.wdata & rau_pkg::MSK_SEC; // RL6
						2'h1: s_d.al.wday = bus_in.wdata & rau_pkg::MSK_WDAY;
						2'h2: s_d.al.month = bus_in.wdata & rau_pkg::MSK_MON;
						2'h3: s_d.al.year = s_q.al.year; // RL25
					endcase
				end
				rau_pkg::ADDR_ALM_LO: begin
					unique case (s_q.alm_cfg[1:0])
						2'h0: s_d.al.sec = bus_in.wdata & rau_pkg::MSK_SEC; // RL6
						2'h1: s_d.al.hour = bus_in.wdata & rau_pkg::MSK_HOUR;
						2'h2: s_d.al.day = bus_in.wdata & rau_pkg::MSK_HOUR;
						2'h3: s_d.al.year = s_q.al.year; // RL25
					endcase
				end
				default: s_d.rd_data = 8'h00;
			endcase
		end

		// Read mux, answered in the following cycle.
		unique case (bus_in.addr)
			rau_pkg::ADDR_CLK_CFG: begin
				rd_val = s_q.clk_cfg;
				rd_val[rau_pkg::CFG_ONE] = 1'b1;
				rd_val[rau_pkg::CFG_SYNC] = s_q.clk_cfg[rau_pkg::CFG_EN] && s_q.half
					&& s_q.pulse >= rau_pkg::SYNC_START; // RL1
				rd_val[rau_pkg::CFG_HALF] = s_q.half;
			end
			rau_pkg::ADDR_TRIM:    rd_val = s_q.trim;
			rau_pkg::ADDR_PAD_CFG: rd_val = s_q.pad_cfg;
			rau_pkg::ADDR_ALM_CFG: rd_val = s_q.alm_cfg;
			rau_pkg::ADDR_RPT:     rd_val = s_q.rpt;
			rau_pkg::ADDR_VAL_HI: begin
				unique case (s_q.clk_cfg[1:0])
					2'h0: rd_val = s_q.tm.min; // RL4
					2'h1: rd_val = s_q.tm.wday;
					2'h2: rd_val = s_q.tm.month;
					2'h3: rd_val = 8'h00; // RL25
				endcase
			end
			rau_pkg::ADDR_VAL_LO: begin
				unique case (s_q.clk_cfg[1:0])
					2'h0: rd_val = s_q.tm.sec;
					2'h1: rd_val = s_q.tm.hour;
					2'h2: rd_val = s_q.tm.day;
					2'h3: rd_val = s_q.tm.year;
				endcase
			end
			rau_pkg::ADDR_ALM_HI: begin
				unique case (s_q.alm_cfg[1:0])
					2'h0: rd_val = s_q.al.min; // RL6
					2'h1: rd_val = s_q.al.wday;
					2'h2: rd_val = s_q.al.month;
					2'h3: rd_val = 8'h00; // RL25
				endcase
			end
			rau_pkg::ADDR_ALM_LO: begin
				unique case (s_q.alm_cfg[1:0])
					2'h0: rd_val = s_q.al.sec;
					2'h1: rd_val = s_q.al.hour;
					2'h2: rd_val = s_q.al.day;
					2'h3: rd_val = 8'h00; // RL25
				endcase
			end
			default: rd_val = 8'h00;
		endcase
		if (bus_in.rd) begin
			s_d.rd_data = rd_val;
		end

		// Any high window access steps its pointer down, after the write above.
		if ((bus_in.rd || bus_in.wr) && bus_in.addr == rau_pkg::ADDR_VAL_HI) begin
			s_d.clk_cfg[1:0] = ptr_dec(s_q.clk_cfg[1:0]); // RL5
		end
		if ((bus_in.rd || bus_in.wr) && bus_in.addr == rau_pkg::ADDR_ALM_HI) begin
			s_d.alm_cfg[1:0] = ptr_dec(s_q.alm_cfg[1:0]); // RL7
		end

		// A device reset short of power-on drops the count and the alarm only.
		if (dev_reset_in) begin
			s_d.rpt = rau_pkg::RPT_RST; // RL20
			s_d.alm_cfg[rau_pkg::ALM_EN] = 1'b0; // RL20
		end

		// Pin source choice, registered so the pin is glitch free.
		unique case (s_q.pad_cfg[rau_pkg::PAD_SEL_LO +: 2])
			rau_pkg::SEL_ALM: s_d.pin = s_d.apulse; // RL18
			rau_pkg::SEL_SEC: s_d.pin = s_d.half; // RL18
			default:          s_d.pin = 1'b0;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------

	// Power-on reset is the only reset that clears clock configuration and trim.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
			s_q.clk_cfg <= rau_pkg::CFG_RST; // RL21
			s_q.rpt <= rau_pkg::RPT_RST; // RL21
			s_q.key <= rau_pkg::RAU_KEY_IDLE;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign rd_data_out = s_q.rd_data;
	assign alarm_irq_out = s_q.irq;
	assign clock_pin_out = s_q.pin;
	assign clock_pin_oe_out = s_q.clk_cfg[rau_pkg::CFG_OE];

endmodule // rau_unit

// >>> dv/rau_checker.sv
`timescale 1ns/10ps

// ----------------------------------------
// Port checks
// ----------------------------------------
module rau_checker (
	input wire logic              clk_in,
	input wire logic              reset_n_in,
	input wire logic              ce_in,
	input wire logic              dev_reset_in,
	input wire logic              sleep_in,
	input wire rau_pkg::rau_bus_t bus_in,
	input wire logic [7:0]        rd_data_out,
	input wire logic              alarm_irq_out,
	input wire logic              clock_pin_out,
	input wire logic              clock_pin_oe_out
);
	logic [1:0] sel_q;
	logic       k1_q;
	logic       arm_q;
	logic       unl_q;
	logic       en_q;
	logic       oe_q;
	logic       cfg_wr;
	assign cfg_wr = bus_in.wr && bus_in.addr == rau_pkg::ADDR_CLK_CFG;

	// Shadows of the key sequence, the lock bits and the pin select.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			{sel_q, k1_q, arm_q, unl_q, en_q, oe_q} <= '0;
		end else if (ce_in) begin
			k1_q  <= bus_in.wr && bus_in.addr == rau_pkg::ADDR_KEY && bus_in.wdata == 8'h55;
			arm_q <= bus_in.wr && bus_in.addr == rau_pkg::ADDR_KEY && bus_in.wdata == 8'hAA && k1_q;
			if (bus_in.wr && bus_in.addr == rau_pkg::ADDR_PAD_CFG) begin
				sel_q <= bus_in.wdata[2:1];
			end
			if (cfg_wr) begin
				unl_q <= bus_in.wdata[5] && (arm_q || unl_q);
				oe_q  <= bus_in.wdata[2];
				if (unl_q) begin
					en_q <= bus_in.wdata[7];
				end
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	rd_idle_a: assert property (ce_in && !bus_in.rd |=> rd_data_out == 8'h00)
		else $error("read data not zero outside a read answer");
	unmapped_zero_a: assert property (ce_in && bus_in.rd && bus_in.addr > rau_pkg::ADDR_KEY
		|=> rd_data_out == 8'h00) else $error("unmapped read not zero");
	cfg_lock_a: assert property (ce_in && bus_in.rd && !dev_reset_in
		&& bus_in.addr == rau_pkg::ADDR_CLK_CFG
		|=> rd_data_out[7:5] == {$past(en_q), 1'b1, $past(unl_q)}) else $error("lock bits wrong");
	oe_follow_a: assert property (oe_q == $past(oe_q) && oe_q == $past(oe_q, 2)
		|-> clock_pin_oe_out == oe_q) else $error("pin enable differs from config");
	irq_single_a: assert property (ce_in && alarm_irq_out |=> !alarm_irq_out)
		else $error("alarm request longer than one cycle");
	pin_alarm_a: assert property (sel_q == 2'h0 && $past(sel_q) == 2'h0
		&& $past(sel_q, 2) == 2'h0 && $changed(clock_pin_out) |-> alarm_irq_out)
		else $error("alarm pulse toggled without alarm");
	pin_off_a: assert property (sel_q[1] && $past(sel_q[1]) && $past(sel_q[1], 2)
		|-> !clock_pin_out) else $error("pin driven with no source selected");
	freeze_hold_a: assert property (!ce_in |=> $stable(rd_data_out) && $stable(alarm_irq_out)
		&& $stable(clock_pin_out) && $stable(clock_pin_oe_out)) else $error("outputs moved while frozen");
endmodule // rau_checker

bind rau_unit rau_checker u_rau_checker (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
	.dev_reset_in(dev_reset_in), .sleep_in(sleep_in), .bus_in(bus_in), .rd_data_out(rd_data_out),
	.alarm_irq_out(alarm_irq_out), .clock_pin_out(clock_pin_out),
	.clock_pin_oe_out(clock_pin_oe_out));

// >>> dv/tb_rau_unit.sv
`timescale 1ns/10ps

// ----------------------------------------
// Register port bench
// ----------------------------------------
module tb_rau_unit;
	logic              clk_in       = 1'b0;
	logic              reset_n_in   = 1'b0;
	logic              ce_in        = 1'b1;
	logic              dev_reset_in = 1'b0;
	logic              sleep_in     = 1'b0;
	rau_pkg::rau_bus_t bus_in       = '0;
	logic [7:0]        rd_data_out;
	logic              alarm_irq_out;
	logic              clock_pin_out;
	logic              clock_pin_oe_out;
	int                num_errors   = 0;
	int                total_checks = 0;
	logic [7:0]        lfsr         = 8'h2D;
	logic [7:0]        tv;
	logic [7:0]        th[4];
	logic [7:0]        tl[4];
	logic [7:0]        ah[4];
	logic [7:0]        al[4];
	int                m_rpt;
	int                m_en;
	logic              m_pin        = 1'b0;

	// Clock at 20 MHz.
	always #25 clk_in = ~clk_in;

	// Sleep wanders randomly; timekeeping must not care.
	always @(posedge clk_in) sleep_in <= lfsr[0];

	// One clock per source pulse, so a half second lasts 16384 cycles.
	rau_unit #(.SRC_CYCLES(1)) u_rau_unit (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
		.dev_reset_in(dev_reset_in), .sleep_in(sleep_in), .bus_in(bus_in),
		.rd_data_out(rd_data_out), .alarm_irq_out(alarm_irq_out),
		.clock_pin_out(clock_pin_out), .clock_pin_oe_out(clock_pin_oe_out));

	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic drive(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
		@(posedge clk_in);
		bus_in <= '{a, d, w, r};
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		drive(a, d, 1'b1, 1'b0);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		drive(a, 8'h00, 1'b0, 1'b1);
		drive(4'h0, 8'h00, 1'b0, 1'b0);
		@(negedge clk_in);
		check(e, rd_data_out);
	endtask

	// Key sequence: 0 clean, 1 idle gap before the config write, 2 stray write inside.
	task automatic key(input int mode);
		wr(rau_pkg::ADDR_KEY, 8'h55);
		if (mode == 2) wr(rau_pkg::ADDR_TRIM, 8'h00);
		wr(rau_pkg::ADDR_KEY, 8'hAA);
		if (mode == 1) drive(4'h0, 8'h00, 1'b0, 1'b0);
		wr(rau_pkg::ADDR_CLK_CFG, 8'h23);
	endtask

	// Fill a window pair from pointer 3 down, then read it back the same way.
	task automatic windows(input logic [3:0] ha, input logic [3:0] la, input logic [3:0] ca,
		input logic [7:0] base, input logic [7:0] h[4], input logic [7:0] l[4]);
		wr(ca, base | 8'h03);
		for (int p = 3; p >= 0; p--) begin
			wr(la, (p == 3 && l[3] == 8'h00) ? 8'h11 : l[p]);
			wr(ha, (p == 3) ? 8'h11 : h[p]);
			rd(ca, base | 8'((p == 0) ? 0 : p - 1));
		end
		wr(ca, base | 8'h03);
		for (int p = 3; p >= 0; p--) begin
			rd(la, l[p]);
			rd(ha, (p == 3) ? 8'h00 : h[p]);
		end
		rd(ca, base);
	endtask

	// Waits a bounded time for an alarm, steps the model, then checks pin and registers.
	task automatic alarm_step(input int endless);
		int n;
		n = 0;
		while (alarm_irq_out !== 1'b1 && n < 20000) begin
			@(negedge clk_in);
			n++;
		end
		check(8'h01, {7'h00, alarm_irq_out});
		if (n >= 20000) close_out;
		m_pin = !m_pin;
		if (m_rpt > 0) begin
			m_rpt--;
		end else if (endless != 0) begin
			m_rpt = 255;
		end else begin
			m_en = 0;
		end
		check({7'h00, m_pin}, {7'h00, clock_pin_out});
		rd(rau_pkg::ADDR_RPT, 8'(m_rpt));
		rd(rau_pkg::ADDR_ALM_CFG, 8'(m_en * 128 + endless * 64));
	endtask

	// Main sequence.
	initial begin
		th = '{8'h59, 8'h05, 8'h12, 8'h00};
		tl = '{8'h58, 8'h23, 8'h31, 8'h24};
		ah = '{8'h30, 8'h03, 8'h02, 8'h00};
		al = '{8'h15, 8'h07, 8'h29, 8'h00};
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rd(rau_pkg::ADDR_CLK_CFG, 8'h40);
		rd(rau_pkg::ADDR_RPT, 8'h00);
		rd(rau_pkg::ADDR_ALM_CFG, 8'h00);
		wr(rau_pkg::ADDR_CLK_CFG, 8'hA3);
		rd(rau_pkg::ADDR_CLK_CFG, 8'h43);
		wr(rau_pkg::ADDR_VAL_LO, 8'h24);
		rd(rau_pkg::ADDR_VAL_LO, 8'h00);
		for (int m = 2; m >= 0; m--) begin
			key(m);
			rd(rau_pkg::ADDR_CLK_CFG, (m == 0) ? 8'h63 : 8'h43);
		end
		windows(rau_pkg::ADDR_VAL_HI, rau_pkg::ADDR_VAL_LO, rau_pkg::ADDR_CLK_CFG, 8'h60, th, tl);
		windows(rau_pkg::ADDR_ALM_HI, rau_pkg::ADDR_ALM_LO, rau_pkg::ADDR_ALM_CFG, 8'h00, ah, al);
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			tv = lfsr;
			wr(rau_pkg::ADDR_TRIM, tv);
			rd(rau_pkg::ADDR_TRIM, tv);
			lfsr = lfsr_next(lfsr);
			wr(rau_pkg::ADDR_RPT, lfsr | 8'h01);
			rd(rau_pkg::ADDR_RPT, lfsr | 8'h01);
		end
		wr(rau_pkg::ADDR_ALM_CFG, 8'hC0);
		drive(4'h0, 8'h00, 1'b0, 1'b0);
		@(posedge clk_in) dev_reset_in <= 1'b1;
		@(posedge clk_in) dev_reset_in <= 1'b0;
		rd(rau_pkg::ADDR_RPT, 8'h00);
		rd(rau_pkg::ADDR_ALM_CFG, 8'h40);
		rd(rau_pkg::ADDR_CLK_CFG, 8'h60);
		rd(rau_pkg::ADDR_TRIM, tv);
		wr(rau_pkg::ADDR_CLK_CFG, 8'hA4);
		rd(rau_pkg::ADDR_CLK_CFG, 8'hE4);
		wr(rau_pkg::ADDR_CLK_CFG, 8'h84);
		rd(rau_pkg::ADDR_CLK_CFG, 8'hC4);
		wr(rau_pkg::ADDR_CLK_CFG, 8'h00);
		rd(rau_pkg::ADDR_CLK_CFG, 8'hC0);
		wr(rau_pkg::ADDR_PAD_CFG, 8'h04);
		rd(rau_pkg::ADDR_PAD_CFG, 8'h04);
		repeat (3) @(negedge clk_in);
		check(8'h00, {7'h00, clock_pin_out});
		wr(rau_pkg::ADDR_PAD_CFG, 8'h02);
		rd(rau_pkg::ADDR_PAD_CFG, 8'h02);
		wr(rau_pkg::ADDR_PAD_CFG, 8'h00);
		wr(4'hB, 8'hFF);
		for (int a = 10; a < 16; a++) rd(4'(a), 8'h00);
		// Alarm every half second: two counted alarms, then endless repeat.
		wr(rau_pkg::ADDR_RPT, 8'h01);
		wr(rau_pkg::ADDR_ALM_CFG, 8'h80);
		drive(4'h0, 8'h00, 1'b0, 1'b0);
		m_rpt = 1;
		m_en = 1;
		alarm_step(0);
		alarm_step(0);
		wr(rau_pkg::ADDR_ALM_CFG, 8'hC0);
		drive(4'h0, 8'h00, 1'b0, 1'b0);
		m_en = 1;
		alarm_step(1);
		@(posedge clk_in) ce_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		ce_in <= 1'b1;
		rd(rau_pkg::ADDR_PAD_CFG, 8'h00);
		close_out;
	end

	// Watchdog against a hung run.
	initial begin
		#(50 * 95000);
		num_errors++;
		close_out;
	end
endmodule // tb_rau_unit
